// ==== logic/qdp_defs.vh ====
// Constants for the queue data window and interrupt enable block
`ifndef QDP_DEFS_VH
`define QDP_DEFS_VH
`define QDP_BANK_DATA        5'h11
`define QDP_BANK_IRQ         5'h12
`define QDP_OFS_IRQ_EN       8'h00
`define QDP_OFS_IRQ_STAT     8'h02
`define QDP_OFS_RX_PTR       8'h06
`define QDP_OFS_TX_PTR       8'h04
`define QDP_OFS_DATA_LOW     8'h08
`define QDP_OFS_DATA_HIGH    8'h0A
`define QDP_IRQ_EN_RESET     16'h0000
`define QDP_IRQ_STAT_RESET   16'h0300
`define QDP_IRQ_WR_MASK      16'hEB80
`define QDP_BIT_LINK_CHANGE  15
`define QDP_BIT_TX_DONE      14
`define QDP_BIT_RX_FRAME     13
`define QDP_BIT_RX_OVERRUN   11
`define QDP_BIT_TX_HALTED    9
`define QDP_BIT_RX_HALTED    8
`define QDP_BIT_RX_ERROR     7
`define QDP_PTR_AUTO_BIT     14
`define QDP_PTR_W            11
`define QDP_BUF_WORDS        512
`define QDP_BUF_AW           9
`define QDP_PTR_WR_MASK      16'h47FF
`define QDP_PTR_RESET        16'h0000
`endif

// ==== logic/qdp_frame_buffer.v ====
// One-way frame buffer, 32-bit words with byte write enables
`timescale 1ns/10ps
`default_nettype none
`include "qdp_defs.vh"
module qdp_frame_buffer (
  input  wire                     clock,
  input  wire [3:0]               wr_be,
  input  wire [`QDP_BUF_AW-1:0]   wr_index,
  input  wire [31:0]              wr_data,
  input  wire [`QDP_BUF_AW-1:0]   rd_index,
  output wire [31:0]              rd_data
);
  reg [31:0] mem_reg [0:`QDP_BUF_WORDS-1];
  integer i;
  assign rd_data = mem_reg[rd_index];
  always @(posedge clock) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (wr_be[i]) begin
        mem_reg[wr_index][8*i +: 8] <= wr_data[8*i +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/qdp_queue_port.v ====
// Queue data window, frame pointers and interrupt enable/status registers
`timescale 1ns/10ps
`default_nettype none
`include "qdp_defs.vh"
// Contract
// - Low data word location shows low 16 bits at the frame pointer.
// - High data word location shows high 16 bits at the frame pointer.
// - Reads come from receive queue; writes go to transmit queue.
// - Window works for even, odd or double-word aligned pointers.
// - Byte, word and double-word accesses mix freely in any order.
// - 16-bit bus: two word locations; 32-bit bus: one double-word location.
// - Enable register gates each interrupt source with one bit.
// - Bit 15 enables link change interrupt; resets to zero.
// - Bit 14 enables transmit-complete interrupt; resets to zero.
// - Bit 13 enables frame-received interrupt; resets to zero.
// - Bit 11 enables receive overrun; bits 12 and 10 reserved zero.
// - Bit 9 enables transmit-halted interrupt; resets to zero.
// - Bit 8 enables receive-halted interrupt; resets to zero.
// - Bit 7 enables receive error frame; bits 6..0 read-only zero.
// - Interrupt output asserts when any status bit and its enable are set.
// - Status bits are not cleared on read; writing one clears them.
// - Auto-increment advances pointer by the number of enabled byte lanes per access.
module qdp_queue_port (
  input  wire                  clock,
  input  wire                  rst_n,
  input  wire                  host_sel,
  input  wire                  host_wr,
  input  wire [4:0]            host_bank,
  input  wire [7:0]            host_addr,
  input  wire [3:0]            host_be,
  input  wire [31:0]           host_wdata,
  input  wire                  bus_is_32,
  input  wire [15:0]           irq_event,
  input  wire [3:0]            rx_fill_be,
  input  wire [`QDP_BUF_AW-1:0] rx_fill_index,
  input  wire [31:0]           rx_fill_data,
  input  wire [`QDP_BUF_AW-1:0] tx_drain_index,
  output reg  [31:0]           host_rdata,
  output reg                   host_ack,
  output reg                   irq_n,
  output reg  [31:0]           tx_drain_data
);
  reg  [15:0]             irq_en_reg;
  reg  [15:0]             irq_stat_reg;
  reg  [15:0]             tx_ptr_reg;
  reg  [15:0]             rx_ptr_reg;
  wire [31:0]             rx_word0;
  wire [31:0]             rx_word1;
  wire [31:0]             tx_even_rd;
  wire [31:0]             tx_odd_rd;
  wire [3:0]              tx_even_be;
  wire [3:0]              tx_odd_be;
  wire [`QDP_BUF_AW-1:0]  tx_even_index;
  wire [`QDP_BUF_AW-1:0]  tx_odd_index;
  wire [`QDP_BUF_AW-1:0]  tx_drain_half;
  reg  [3:0]              tx_be0;
  reg  [3:0]              tx_be1;
  reg  [31:0]             tx_wdata;
  reg  [31:0]             win_rdata;
  reg  [2:0]              acc_bytes;
  reg  [31:0]             win_host_data;
  reg  [15:0]             stat_next;
  reg  [`QDP_PTR_W-1:0]   ptr_sel;
  wire [1:0]              ptr_off;
  wire [`QDP_BUF_AW-1:0]  ptr_word;
  wire [`QDP_BUF_AW-1:0]  ptr_word_nx;
  wire                    acc_data_bank;
  wire                    acc_irq_bank;
  wire                    hit_window;
  wire                    win_wr;
  wire                    win_rd;
  wire                    hit_high_16;

  // Count of enabled byte lanes gives the access size
  function [2:0] be_count;
    input [3:0] be;
    begin
      be_count = {2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]};
    end
  endfunction

  // First enabled lane, used to align data for sub-word accesses
  function [1:0] be_first;
    input [3:0] be;
    begin
      if (be[0]) be_first = 2'd0;
      else if (be[1]) be_first = 2'd1;
      else if (be[2]) be_first = 2'd2;
      else be_first = 2'd3;
    end
  endfunction

  // Lanes covered by an access of n bytes, counted from lane 0
  function [3:0] size_lanes;
    input [2:0] n;
    begin
      case (n)
        3'h4: size_lanes = 4'hF;
        3'h2: size_lanes = 4'h3;
        3'h1: size_lanes = 4'h1;
        default: size_lanes = 4'h0;
      endcase
    end
  endfunction

  // Byte lane mask widened to a bit mask
  function [31:0] lane_bits;
    input [3:0] m;
    begin
      lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    end
  endfunction

  // Advance a pointer register keeping its auto-increment bit
  function [15:0] ptr_step;
    input [15:0] p;
    input [2:0]  n;
    begin
      ptr_step = p;
      if (p[`QDP_PTR_AUTO_BIT]) begin
        ptr_step[`QDP_PTR_W-1:0] = p[`QDP_PTR_W-1:0] + {{(`QDP_PTR_W-3){1'b0}}, n};
      end
    end
  endfunction

  assign acc_data_bank = host_bank == `QDP_BANK_DATA;
  assign acc_irq_bank  = host_bank == `QDP_BANK_IRQ;
  // 32-bit bus sees one location at the low offset; 16-bit bus sees two
  assign hit_window  = acc_data_bank && (host_addr == `QDP_OFS_DATA_LOW ||
                       (!bus_is_32 && host_addr == `QDP_OFS_DATA_HIGH));
  assign hit_high_16 = !bus_is_32 && host_addr == `QDP_OFS_DATA_HIGH;
  assign win_wr = host_sel && host_wr && hit_window;
  assign win_rd = host_sel && !host_wr && hit_window;

  always @* begin
    ptr_sel = host_wr ? tx_ptr_reg[`QDP_PTR_W-1:0] : rx_ptr_reg[`QDP_PTR_W-1:0];
  end
  assign ptr_off     = ptr_sel[1:0];
  assign ptr_word    = ptr_sel[`QDP_BUF_AW+1:2];
  assign ptr_word_nx = ptr_word + {{(`QDP_BUF_AW-1){1'b0}}, 1'b1};

  // Host data packed into the low bytes, whatever lanes carried it
  always @* begin
    acc_bytes = be_count(host_be);
    win_host_data = host_wdata >> {be_first(host_be), 3'b000};
    if (hit_high_16) begin
      win_host_data = {16'h0000, host_wdata[31:16]};
    end
  end

  // Unaligned access spans two buffer words; shift data and lanes across both
  always @* begin : tx_align
    reg [7:0] lanes;
    lanes = {4'h0, size_lanes(acc_bytes)} << ptr_off;
    tx_be0 = win_wr ? lanes[3:0] : 4'h0;
    tx_be1 = win_wr ? lanes[7:4] : 4'h0;
    tx_wdata = (win_host_data << {ptr_off, 3'b000}) | (win_host_data >> {~ptr_off + 2'd1, 3'b000});
    if (ptr_off == 2'd0) begin
      tx_wdata = win_host_data;
    end
  end

  // Two buffer words read side by side give any byte alignment
  always @* begin : rx_align
    reg [63:0] pair;
    pair = {rx_word1, rx_word0} >> {ptr_off, 3'b000};
    // Lanes beyond the access size read as zero, so no stale bytes leak out
    win_rdata = pair[31:0] & lane_bits(size_lanes(acc_bytes));
  end

  // Even and odd words live apart, so an unaligned write reaches both words in one cycle
  assign tx_even_be    = ptr_word[0] ? tx_be1 : tx_be0;
  assign tx_odd_be     = ptr_word[0] ? tx_be0 : tx_be1;
  assign tx_even_index = ptr_word[0] ? {1'b0, ptr_word_nx[`QDP_BUF_AW-1:1]} : {1'b0, ptr_word[`QDP_BUF_AW-1:1]};
  assign tx_odd_index  = {1'b0, ptr_word[`QDP_BUF_AW-1:1]};
  assign tx_drain_half = {1'b0, tx_drain_index[`QDP_BUF_AW-1:1]};

  qdp_frame_buffer u_tx_buf_even (
    .clock    (clock),
    .wr_be    (tx_even_be),
    .wr_index (tx_even_index),
    .wr_data  (tx_wdata),
    .rd_index (tx_drain_half),
    .rd_data  (tx_even_rd)
  );

  qdp_frame_buffer u_tx_buf_odd (
    .clock    (clock),
    .wr_be    (tx_odd_be),
    .wr_index (tx_odd_index),
    .wr_data  (tx_wdata),
    .rd_index (tx_drain_half),
    .rd_data  (tx_odd_rd)
  );

  qdp_frame_buffer u_rx_buf (
    .clock    (clock),
    .wr_be    (rx_fill_be),
    .wr_index (rx_fill_index),
    .wr_data  (rx_fill_data),
    .rd_index (ptr_word),
    .rd_data  (rx_word0)
  );

  qdp_frame_buffer u_rx_buf_hi (
    .clock    (clock),
    .wr_be    (rx_fill_be),
    .wr_index (rx_fill_index - {{(`QDP_BUF_AW-1){1'b0}}, 1'b1}),
    .wr_data  (rx_fill_data),
    .rd_index (ptr_word),
    .rd_data  (rx_word1)
  );

  // Status: hardware set wins over host clear; reads leave it alone
  always @* begin
    stat_next = irq_stat_reg;
    if (host_sel && host_wr && acc_irq_bank && host_addr == `QDP_OFS_IRQ_STAT) begin
      stat_next = stat_next & ~(host_wdata[15:0] & `QDP_IRQ_WR_MASK);
    end
    stat_next = stat_next | (irq_event & `QDP_IRQ_WR_MASK);
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      irq_en_reg   <= `QDP_IRQ_EN_RESET;
      irq_stat_reg <= `QDP_IRQ_STAT_RESET;
      tx_ptr_reg   <= `QDP_PTR_RESET;
      rx_ptr_reg   <= `QDP_PTR_RESET;
      host_rdata   <= 32'h0000_0000;
      host_ack     <= 1'b0;
      irq_n        <= 1'b1;
      tx_drain_data <= 32'h0000_0000;
    end else begin
      host_ack      <= host_sel;
      irq_stat_reg  <= stat_next;
      tx_drain_data <= tx_drain_index[0] ? tx_odd_rd : tx_even_rd;
      // Reserved enable bits 12, 10 and 6..0 never take a one
      if (host_sel && host_wr && acc_irq_bank && host_addr == `QDP_OFS_IRQ_EN) begin
        irq_en_reg <= host_wdata[15:0] & `QDP_IRQ_WR_MASK;
      end
      if (host_sel && host_wr && acc_data_bank && host_addr == `QDP_OFS_TX_PTR) begin
        tx_ptr_reg <= host_wdata[15:0] & `QDP_PTR_WR_MASK;
      end else if (win_wr) begin
        tx_ptr_reg <= ptr_step(tx_ptr_reg, acc_bytes);
      end
      if (host_sel && host_wr && acc_data_bank && host_addr == `QDP_OFS_RX_PTR) begin
        rx_ptr_reg <= host_wdata[15:0] & `QDP_PTR_WR_MASK;
      end else if (win_rd) begin
        rx_ptr_reg <= ptr_step(rx_ptr_reg, acc_bytes);
      end
      host_rdata <= 32'h0000_0000;
      if (win_rd) begin
        host_rdata <= hit_high_16 ? {win_rdata[15:0], 16'h0000} : win_rdata;
      end else if (host_sel && !host_wr && acc_irq_bank) begin
        if (host_addr == `QDP_OFS_IRQ_EN) host_rdata <= {16'h0000, irq_en_reg};
        if (host_addr == `QDP_OFS_IRQ_STAT) host_rdata <= {16'h0000, irq_stat_reg};
      end else if (host_sel && !host_wr && acc_data_bank) begin
        if (host_addr == `QDP_OFS_TX_PTR) host_rdata <= {16'h0000, tx_ptr_reg};
        if (host_addr == `QDP_OFS_RX_PTR) host_rdata <= {16'h0000, rx_ptr_reg};
      end
      irq_n <= ~|(stat_next & irq_en_reg);
    end
  end
endmodule
`default_nettype wire

// ==== sim/qdp_host_model.sv ====
// Host processor model on the register bus
`timescale 1ns/10ps
`default_nettype none
module qdp_host_model (
  input  wire logic        clock,
  input  wire logic        host_ack,
  input  wire logic [31:0] host_rdata,
  output logic             host_sel,
  output logic             host_wr,
  output logic [4:0]       host_bank,
  output logic [7:0]       host_addr,
  output logic [3:0]       host_be,
  output logic [31:0]      host_wdata
);
  initial {host_sel, host_wr, host_bank, host_addr, host_be, host_wdata} = '0;
  // Any access size may follow any other
  task automatic xfer(input logic w, input logic [12:0] ba, input logic [3:0] e,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    {host_sel, host_wr, host_bank, host_addr, host_be, host_wdata} <= {1'b1, w, ba, e, d};
    @(posedge clock);
    host_sel <= 1'b0;
    // Released data must not look like the last value
    host_wdata <= ~d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (host_ack !== 1'b1 && n < 8);
    q = host_rdata;
  endtask
endmodule
`default_nettype wire

// ==== sim/qdp_port_monitor.sv ====
// Port checker for the queue data window block
`timescale 1ns/10ps
`default_nettype none
module qdp_port_monitor (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        host_sel,
  input wire logic        host_wr,
  input wire logic [15:0] irq_event,
  input wire logic [31:0] host_rdata,
  input wire logic        host_ack,
  input wire logic        irq_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire host_write = host_sel && host_wr;
  chk_ack_follows: assert property (host_sel |=> host_ack) else $error("ack missing");
  chk_ack_cause: assert property (!host_sel |=> !host_ack) else $error("stray ack");
  chk_rdata_idle: assert property (!host_ack |-> host_rdata == 32'h0) else $error("rdata not idle");
  chk_write_quiet: assert property (host_sel && host_wr |=> host_rdata == 32'h0) else $error("write data");
  // An event shows on the pin one cycle later, an enable write two cycles later
  chk_irq_cause: assert property ($fell(irq_n) |-> $past(irq_event != 16'h0) || $past(host_write, 2))
    else $error("irq without cause");
  // A status clear shows one cycle later, an enable write two cycles later
  chk_irq_release: assert property ($rose(irq_n) |-> $past(host_write) || $past(host_write, 2) || !$past(rst_n))
    else $error("irq dropped alone");
  chk_irq_quiet: assert property ((!host_sel && irq_event == 16'h0) [*2] |=> $stable(irq_n))
    else $error("irq moved idle");
  chk_reset_state: assert property (!$past(rst_n) |-> irq_n && !host_ack) else $error("reset state");
  cov_write: cover property (host_sel && host_wr);
  cov_read: cover property (host_ack && host_rdata != 32'h0);
  cov_irq: cover property ($fell(irq_n));
  cov_irq_release: cover property ($rose(irq_n));
endmodule
bind qdp_queue_port qdp_port_monitor i_mon (
  .clock      (clock),
  .rst_n      (rst_n),
  .host_sel   (host_sel),
  .host_wr    (host_wr),
  .irq_event  (irq_event),
  .host_rdata (host_rdata),
  .host_ack   (host_ack),
  .irq_n      (irq_n)
);
`default_nettype wire

// ==== sim/tb_queue_data_port_irq_enable.sv ====
// Testbench for the queue data window block
`timescale 1ns/10ps
`default_nettype none
module tb_queue_data_port_irq_enable;
  logic        clock = 0, rst_n = 0, bus_is_32 = 1, host_sel, host_wr, host_ack, irq_n;
  logic [15:0] irq_event = '0;
  logic [3:0]  rx_fill_be = '0, host_be;
  logic [8:0]  rx_fill_index = '0, tx_drain_index = '0;
  logic [31:0] rx_fill_data = '0, q, host_rdata, host_wdata, tx_drain_data;
  logic [4:0]  host_bank;
  logic [7:0]  host_addr;
  int          error_cnt = 0, check_count = 0;
  int          bits[7] = '{15, 14, 13, 11, 9, 8, 7};
  always #20 clock = ~clock;
  qdp_host_model i_host (
    .clock      (clock),
    .host_ack   (host_ack),
    .host_rdata (host_rdata),
    .host_sel   (host_sel),
    .host_wr    (host_wr),
    .host_bank  (host_bank),
    .host_addr  (host_addr),
    .host_be    (host_be),
    .host_wdata (host_wdata)
  );
  qdp_queue_port i_dut (
    .clock          (clock),
    .rst_n          (rst_n),
    .host_sel       (host_sel),
    .host_wr        (host_wr),
    .host_bank      (host_bank),
    .host_addr      (host_addr),
    .host_be        (host_be),
    .host_wdata     (host_wdata),
    .bus_is_32      (bus_is_32),
    .irq_event      (irq_event),
    .rx_fill_be     (rx_fill_be),
    .rx_fill_index  (rx_fill_index),
    .rx_fill_data   (rx_fill_data),
    .tx_drain_index (tx_drain_index),
    .host_rdata     (host_rdata),
    .host_ack       (host_ack),
    .irq_n          (irq_n),
    .tx_drain_data  (tx_drain_data)
  );
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic t_enables;
    i_host.xfer(0, 13'h1200, 4'h3, 0, q);
    cmp("enables reset", 0, q);
    i_host.xfer(1, 13'h1200, 4'h3, 32'hFFFF, q);
    i_host.xfer(0, 13'h1200, 4'h3, 0, q);
    cmp("enables mask", 32'hEB80, q);
    i_host.xfer(0, 13'h120E, 4'h3, 0, q);
    cmp("unmapped", 0, q);
  endtask
  task automatic t_irq;
    logic [15:0] m;
    i_host.xfer(1, 13'h1202, 4'h3, 32'h0300, q);
    foreach (bits[i]) begin
      m = 16'h1 << bits[i];
      i_host.xfer(1, 13'h1200, 4'h3, 0, q);
      @(posedge clock) irq_event <= m;
      @(posedge clock) irq_event <= '0;
      tick(3);
      cmp("masked irq", 1, irq_n);
      i_host.xfer(1, 13'h1200, 4'h3, m, q);
      tick(3);
      cmp("irq", 0, irq_n);
      i_host.xfer(0, 13'h1202, 4'h3, 0, q);
      cmp("status", m, q);
      i_host.xfer(1, 13'h1202, 4'h3, m, q);
      tick(3);
      cmp("irq clear", 1, irq_n);
    end
    // A clear that lands together with a new event must keep the event
    fork
      i_host.xfer(1, 13'h1202, 4'h3, m, q);
      begin
        @(posedge clock) irq_event <= m;
        @(posedge clock) irq_event <= '0;
      end
    join
    tick(3);
    cmp("set wins irq", 0, irq_n);
    i_host.xfer(0, 13'h1202, 4'h3, 0, q);
    cmp("set wins status", m, q);
    i_host.xfer(1, 13'h1202, 4'h3, m, q);
    tick(3);
    cmp("final clear", 1, irq_n);
  endtask
  task automatic t_reset;
    i_host.xfer(1, 13'h1200, 4'h3, 32'hFFFF, q);
    @(posedge clock) rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    i_host.xfer(0, 13'h1200, 4'h3, 0, q);
    cmp("enables after reset", 0, q);
    i_host.xfer(0, 13'h1202, 4'h3, 0, q);
    cmp("status after reset", 32'h0300, q);
    i_host.xfer(1, 13'h1202, 4'h3, 32'h0300, q);
  endtask
  task automatic fill(input logic [8:0] i, input logic [31:0] d);
    @(posedge clock) {rx_fill_be, rx_fill_index, rx_fill_data} <= {4'hF, i, d};
    @(posedge clock) rx_fill_be <= '0;
  endtask
  task automatic t_window;
    fill(0, 32'h44332211);
    fill(1, 32'h88776655);
    i_host.xfer(1, 13'h1106, 4'h3, 32'h4001, q);
    i_host.xfer(0, 13'h1108, 4'hF, 0, q);
    cmp("odd dword", 32'h55443322, q);
    i_host.xfer(0, 13'h1108, 4'h1, 0, q);
    cmp("byte", 32'h66, q);
    i_host.xfer(0, 13'h1108, 4'h3, 0, q);
    cmp("word", 32'h8877, q);
    i_host.xfer(0, 13'h110A, 4'hC, 0, q);
    cmp("high in 32-bit", 0, q);
    i_host.xfer(1, 13'h1104, 4'h3, 32'h4002, q);
    i_host.xfer(1, 13'h1108, 4'h3, 32'hBEEF, q);
    i_host.xfer(1, 13'h1108, 4'hF, 32'hCAFE1234, q);
    tx_drain_index <= 9'h0;
    tick(2);
    cmp("tx high", 32'hBEEF, tx_drain_data[31:16]);
    tx_drain_index <= 9'h1;
    tick(2);
    cmp("tx dword", 32'hCAFE1234, tx_drain_data);
    i_host.xfer(1, 13'h1104, 4'h3, 32'h4003, q);
    i_host.xfer(1, 13'h1108, 4'hF, 32'hA1B2C3D4, q);
    tick(2);
    cmp("tx split high", 32'hCAA1B2C3, tx_drain_data);
    tx_drain_index <= 9'h0;
    tick(2);
    cmp("tx split low", 32'hD4EF, tx_drain_data[31:16]);
    bus_is_32 <= 1'b0;
    i_host.xfer(1, 13'h1106, 4'h3, 32'h4000, q);
    i_host.xfer(0, 13'h1108, 4'h3, 0, q);
    cmp("low word", 32'h2211, q);
    i_host.xfer(0, 13'h110A, 4'hC, 0, q);
    cmp("high word", 32'h44330000, q);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(6);
    rst_n <= 1'b1;
    t_enables;
    t_irq;
    t_reset;
    t_window;
    summarize;
  end
  initial begin
    #200000;
    error_cnt++;
    summarize;
  end
endmodule
`default_nettype wire
